/* File: ssp_cfg.svh */
/*
  Constants of the serial slave port: clock rate, register map, field
  positions, reset values and framing counts.
  Assumes it is included by its bare name; it needs nothing from the package.
*/
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
// Overview of operation
// RULE1: Disabled port neither transmits nor answers.
// RULE2: Twelve selectable bit rates, 110 to 115200.
// RULE3: Parity none, odd, even, mark or space.
// RULE4: Five to eight data bits per character.
// RULE5: One or two stop bits end each character.
// RULE6: Partner uses the same parity choice.
// RULE7: Partner uses the same stop-bit count.
// RULE8: Lead delay in ms after request-to-send rises.
// RULE9: Tail delay in ms before request-to-send falls.
// RULE10: With gating on, send only while clear-to-send high; checked only as each character starts, so a character in flight still finishes.
// RULE11: With gating off, clear-to-send is ignored.
// RULE12: Only messages with our node address are taken.
// RULE13: Low start, data LSB first, parity, high stops.
// RULE14: Mark is one, space zero; mismatch flagged.

`define SSP_CLK_HZ 40000000
`define SSP_MS_PER_S 1000
`define SSP_BAUD_RATES '{110, 150, 300, 600, 1200, 2400, 4800, 9600, 19200, 28800, 57600, 115200}
`define SSP_BAUD_COUNT 12
`define SSP_DBITS_MIN 4'h5
`define SSP_IDLE_BITS 4'hA

// Word indices; the byte address is four times the index.
`define SSP_REG_CTRL 3'h0
`define SSP_REG_NODE 3'h1
`define SSP_REG_LEAD 3'h2
`define SSP_REG_TAIL 3'h3
`define SSP_REG_TXD 3'h4
`define SSP_REG_RXD 3'h5
`define SSP_REG_STAT 3'h6

// Control fields.
`define SSP_CTRL_EN 0
`define SSP_CTRL_CTS 1
`define SSP_CTRL_STOP2 2
`define SSP_CTRL_PAR 5:3
`define SSP_CTRL_DBITS 7:6
`define SSP_CTRL_BAUD 11:8
`define SSP_CTRL_W 12
`define SSP_CTRL_RST 12'h4C1
`define SSP_NODE_RST 8'h01

// Status fields, then receive data word fields.
`define SSP_ST_PERR 6
`define SSP_ST_FERR 7
`define SSP_ST_OVR 8
`define SSP_RXD_FULL 8
`define SSP_RXD_PERR 9
`endif

/* File: ssp_pkg.sv */
/*
  Types and shared functions of the serial slave port.
  Assumes ssp_cfg.svh is available on the include path.
*/
`include "ssp_cfg.svh"
package ssp_pkg;
  // Parity encodings as software writes them.
  typedef enum logic [2:0] {
    SSP_PAR_NONE = 3'h0,
    SSP_PAR_ODD = 3'h1,
    SSP_PAR_EVEN = 3'h2,
    SSP_PAR_MARK = 3'h3,
    SSP_PAR_SPACE = 3'h4
  } ssp_par_t;

  // Transmit sequencer states, one-hot.
  typedef enum logic [4:0] {
    SSP_TX_IDLE = 5'h01,
    SSP_TX_LEAD = 5'h02,
    SSP_TX_CTS = 5'h04,
    SSP_TX_SEND = 5'h08,
    SSP_TX_TAIL = 5'h10
  } ssp_tx_t;

  localparam int unsigned SSP_RATES[`SSP_BAUD_COUNT] = `SSP_BAUD_RATES;

  // Clocks per bit for a rate index; out-of-range indices fall back to the slowest rate.
  function automatic logic [18:0] ssp_baud_div(input logic [3:0] sel);
    int unsigned r;
    r = (sel < `SSP_BAUD_COUNT) ? SSP_RATES[sel] : SSP_RATES[0];
    return 19'((`SSP_CLK_HZ + r / 2) / r);
  endfunction

  // Parity bit over the low data bits that the length selects.
  function automatic logic ssp_parity(input logic [7:0] d, input logic [1:0] dbits,
                                      input logic [2:0] mode);
    logic x;
    x = ^(d & 8'(8'hFF >> (2'h3 - dbits)));
    case (mode)
      SSP_PAR_ODD: return ~x;
      SSP_PAR_EVEN: return x;
      SSP_PAR_MARK: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
endpackage

/* File: ssp_fifo.sv */
/*
  Synchronous first-in first-out buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level.
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  // Pointers need a power-of-two depth to wrap cleanly.
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("ssp_fifo depth must be a power of two, at least two");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // Storage words.
  logic [AW:0] wr_ptr; // Write pointer with wrap bit.
  logic [AW:0] rd_ptr; // Read pointer with wrap bit.
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Pointers advance on accepted transfers only.
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end

  // Data words carry no reset; only the pointers decide validity.
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (reset)
    level <= (AW+1)'(DEPTH)) else $error("fifo level beyond depth");
endmodule
`default_nettype wire

/* File: ssp_rx.sv */
/*
  Serial character receiver with parity check and line-gap detection.
  Assumes the receive pin is asynchronous to clk and idles high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"
module ssp_rx
  import ssp_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Line and framing settings.
  input wire logic rxd_pin,
  input wire logic enable,
  input wire logic [18:0] bit_div,
  input wire logic [1:0] dbits,
  input wire logic [2:0] par_mode,
  // Received character.
  output logic char_valid,
  output logic [7:0] char_data,
  output logic parity_err,
  output logic frame_err,
  output logic gap
);
  import ssp_pkg::*;

  logic rx_m; // First synchroniser stage.
  logic rx_s; // Second synchroniser stage, the only one logic reads.
  logic active; // A character is being sampled.
  logic [3:0] idx; // Bit index, zero is the start bit.
  logic [18:0] cnt; // Clocks to the next sample.
  logic [3:0] idle_bits; // Whole bit times of idle line.
  logic [18:0] idle_cnt; // Clocks inside the current idle bit.

  wire [3:0] n_data = {2'h0, dbits} + `SSP_DBITS_MIN;
  wire par_en = (par_mode != SSP_PAR_NONE);
  wire tick = active && (cnt == '0);
  wire in_data = (idx != 4'h0) && (idx <= n_data);
  wire at_par = par_en && (idx == n_data + 4'h1);
  wire at_stop = (idx == n_data + {3'h0, par_en} + 4'h1);

  // Two flops keep the pin from metastability.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_m <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_m <= rxd_pin;
      rx_s <= rx_m;
    end
  end

  // Sample each bit at its middle, counted from the falling start edge.
  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      active <= 1'b0;
      idx <= 4'h0;
      cnt <= '0;
      char_valid <= 1'b0;
      char_data <= 8'h00;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      char_valid <= 1'b0;
      if (!active) begin
        if (!rx_s) begin
          active <= 1'b1; // RULE13
          idx <= 4'h0;
          cnt <= bit_div >> 1;
          char_data <= 8'h00;
        end
      end else if (tick) begin
        cnt <= bit_div - 19'h1;
        idx <= idx + 4'h1;
        if (idx == 4'h0 && rx_s) begin
          active <= 1'b0; // A glitch, not a start bit.
        end
        if (in_data) begin
          char_data[3'(idx - 4'h1)] <= rx_s; // RULE13
        end
        if (at_par) begin
          parity_err <= (rx_s != ssp_parity(char_data, dbits, par_mode)); // RULE14
        end else if (idx == 4'h0) begin
          parity_err <= 1'b0;
        end
        if (at_stop) begin
          active <= 1'b0;
          char_valid <= 1'b1;
          frame_err <= !rx_s; // RULE13
        end
      end else begin
        cnt <= cnt - 19'h1;
      end
    end
  end

  // A quiet line of several bit times closes a message.
  always_ff @(posedge clk) begin
    if (reset || active || !rx_s) begin
      idle_bits <= 4'h0;
      idle_cnt <= '0;
      gap <= 1'b0;
    end else begin
      gap <= 1'b0;
      if (idle_cnt >= bit_div - 19'h1) begin
        idle_cnt <= '0;
        if (idle_bits != `SSP_IDLE_BITS) begin
          idle_bits <= idle_bits + 4'h1;
          gap <= (idle_bits == `SSP_IDLE_BITS - 4'h1);
        end
      end else begin
        idle_cnt <= idle_cnt + 19'h1;
      end
    end
  end

  rx_nopar_a: assert property (@(posedge clk) disable iff (reset)
    char_valid && $past(par_mode) == SSP_PAR_NONE && $past(par_mode, 2) == SSP_PAR_NONE
    |-> !parity_err) else $error("parity error without parity"); // RULE3
endmodule
`default_nettype wire

/* File: ssp_top.sv */
/*
  Serial slave port: Avalon-MM register slave, transmit buffer and
  sequencer with request-to-send timing, receiver with node address filter.
  Assumes a synchronous active-high reset and asynchronous modem pins.
*/
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"
module ssp_top #(
  parameter int unsigned MS_CYCLES = `SSP_CLK_HZ / `SSP_MS_PER_S,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset,
  // Avalon-MM register slave, word addressed.
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Serial line and modem control.
  input wire logic rxd,
  output logic txd,
  output logic rts,
  input wire logic cts
);
  import ssp_pkg::*;

  // The fill level must fit below bit 32 of the status word.
  if (MS_CYCLES < 1 || FIFO_DEPTH < 2 || FIFO_DEPTH > 32768) begin : g_chk
    $error("ssp_top needs MS_CYCLES >= 1 and FIFO_DEPTH from 2 to 32768");
  end

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // Software settings.
  logic [`SSP_CTRL_W-1:0] ctrl; // Enable, gating, stops, parity, length, rate.
  logic [7:0] node_address; // Address this port answers to.
  logic [15:0] lead_ms; // Delay after request-to-send rises.
  logic [15:0] tail_ms; // Delay before request-to-send falls.
  // Receive side state.
  logic [7:0] rx_buf; // Last accepted character.
  logic rx_full; // The buffer holds an unread character.
  logic rx_bperr; // Parity error of the buffered character.
  logic [8:6] sticky; // Parity, framing and overrun flags.
  logic addr_wait; // Next character is a message address.
  logic selected; // Current message is for this node.
  // Transmit side state.
  ssp_tx_t st; // Sequencer state.
  logic [11:0] sh; // Bits still to send after the start bit.
  logic [3:0] left; // Count of those bits.
  logic [18:0] bit_cnt; // Clocks inside the current bit.
  logic [31:0] pre; // Millisecond prescaler.
  logic [15:0] ms_cnt; // Elapsed milliseconds.
  logic cts_m; // First synchroniser stage of clear-to-send.
  logic cts_s; // Second stage, the only one logic reads.

  // Settings decoded.
  wire en = ctrl[`SSP_CTRL_EN];
  wire cts_use = ctrl[`SSP_CTRL_CTS];
  wire stop2 = ctrl[`SSP_CTRL_STOP2];
  wire [2:0] par_mode = ctrl[`SSP_CTRL_PAR];
  wire [1:0] dbits = ctrl[`SSP_CTRL_DBITS];
  wire [18:0] bit_div = ssp_baud_div(ctrl[`SSP_CTRL_BAUD]); // RULE2
  wire [3:0] n_data = {2'h0, dbits} + `SSP_DBITS_MIN; // RULE4
  wire par_en = (par_mode != SSP_PAR_NONE);

  // Bus decode.
  wire req = read || write;
  wire done = req && !waitrequest;
  wire hit_txd = (address == `SSP_REG_TXD);
  wire wr_done = write && done;

  // Buffer and receiver wires.
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire [LW-1:0] fifo_level;
  wire rx_valid;
  wire [7:0] rx_data;
  wire rx_perr;
  wire rx_ferr;
  wire rx_gap;

  // Transmit framing: ones above the data make the stop bits.
  wire [7:0] tx_dm = fifo_out_data & 8'(8'hFF >> (2'h3 - dbits));
  wire tx_par = ssp_parity(fifo_out_data, dbits, par_mode); // RULE3
  wire [11:0] frame_ones = 12'hFFF << n_data;
  wire [11:0] par_pos = 12'h001 << n_data;
  wire [11:0] tx_frame = (frame_ones | {4'h0, tx_dm})
                         & ~((par_en && !tx_par) ? par_pos : 12'h000); // RULE14
  wire [3:0] tx_len = n_data + {3'h0, par_en} + {3'h0, stop2} + 4'h1; // RULE5
  wire bit_tick = (bit_cnt == bit_div - 19'h1);
  wire ms_tick = (pre == MS_CYCLES - 1);
  wire lead_done = (ms_cnt == lead_ms);
  wire tail_done = (ms_cnt == tail_ms);
  wire cts_ok = !cts_use || cts_s; // RULE10 RULE11
  wire load = (st == SSP_TX_CTS) && cts_ok && fifo_out_valid && en;
  wire char_end = (st == SSP_TX_SEND) && bit_tick && (left == 4'h0);

  // Receive filter: the first character after a gap is the address.
  wire addr_match = (rx_data == node_address);
  wire rx_take = rx_valid && (addr_wait ? addr_match : selected); // RULE12
  wire rx_rd_clr = read && done && (address == `SSP_REG_RXD);
  wire stat_wr = wr_done && (address == `SSP_REG_STAT);
  wire [8:6] sticky_set = {rx_take && rx_full && !rx_rd_clr,
                           rx_valid && rx_ferr, rx_valid && rx_perr};

  // Read selection; unmapped words read as zero.
  wire [31:0] status = {{(16-LW){1'b0}}, fifo_level, 7'h00, sticky,
                        selected, !fifo_in_ready, !fifo_out_valid, rts,
                        (st != SSP_TX_IDLE), rx_full};
  wire [31:0] rd_mux =
    (address == `SSP_REG_CTRL) ? {20'h0, ctrl} :
    (address == `SSP_REG_NODE) ? {24'h0, node_address} :
    (address == `SSP_REG_LEAD) ? {16'h0, lead_ms} :
    (address == `SSP_REG_TAIL) ? {16'h0, tail_ms} :
    (address == `SSP_REG_RXD) ? {22'h0, rx_bperr, rx_full, rx_buf} :
    (address == `SSP_REG_STAT) ? status : 32'h0;

  // Characters wait here; a full buffer holds the bus write off.
  ssp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(wr_done && hit_txd),
    .in_ready(fifo_in_ready),
    .in_data(writedata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(load),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // Receiver samples characters only while the port is enabled; its gap detector runs regardless.
  ssp_rx u_rx (
    .clk(clk),
    .reset(reset),
    .rxd_pin(rxd),
    .enable(en), // RULE1
    .bit_div(bit_div),
    .dbits(dbits),
    .par_mode(par_mode),
    .char_valid(rx_valid),
    .char_data(rx_data),
    .parity_err(rx_perr),
    .frame_err(rx_ferr),
    .gap(rx_gap)
  );

  // Answer one cycle after the request, later for a TXD write to a full buffer; read data is captured then too.
  always_ff @(posedge clk) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else begin
      waitrequest <= !(req && waitrequest && (!(write && hit_txd) || fifo_in_ready));
      if (read && waitrequest) readdata <= rd_mux;
    end
  end

  // Settings take effect at the completing edge of a write.
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= `SSP_CTRL_RST;
      node_address <= `SSP_NODE_RST;
      lead_ms <= 16'h0000;
      tail_ms <= 16'h0000;
    end else if (wr_done) begin
      if (address == `SSP_REG_CTRL) ctrl <= writedata[`SSP_CTRL_W-1:0];
      if (address == `SSP_REG_NODE) node_address <= writedata[7:0];
      if (address == `SSP_REG_LEAD) lead_ms <= writedata[15:0];
      if (address == `SSP_REG_TAIL) tail_ms <= writedata[15:0];
    end
  end

  // Received characters and flags; a new event beats a same-cycle clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
      rx_bperr <= 1'b0;
      sticky <= 3'h0;
    end else begin
      sticky <= (sticky & ~(stat_wr ? writedata[8:6] : 3'h0)) | sticky_set;
      if (rx_take) begin
        rx_buf <= rx_data;
        rx_full <= 1'b1;
        rx_bperr <= rx_perr;
      end else if (rx_rd_clr) begin
        rx_full <= 1'b0;
      end
    end
  end

  // Address filter: a gap re-arms it, the first character decides.
  always_ff @(posedge clk) begin
    if (reset || !en) begin
      addr_wait <= 1'b1;
      selected <= 1'b0;
    end else if (rx_gap) begin
      addr_wait <= 1'b1;
    end else if (rx_valid && addr_wait) begin
      addr_wait <= 1'b0;
      selected <= addr_match; // RULE12
    end
  end

  // Clear-to-send crosses in through two flops.
  always_ff @(posedge clk) begin
    if (reset) begin
      cts_m <= 1'b0;
      cts_s <= 1'b0;
    end else begin
      cts_m <= cts;
      cts_s <= cts_m;
    end
  end

  // Millisecond timer, running only in the delay states.
  always_ff @(posedge clk) begin
    if (reset || !(st == SSP_TX_LEAD || st == SSP_TX_TAIL)) begin
      pre <= 32'h0;
      ms_cnt <= 16'h0000;
    end else if (ms_tick) begin
      pre <= 32'h0;
      ms_cnt <= ms_cnt + 16'h0001;
    end else begin
      pre <= pre + 32'h1;
    end
  end

  // Transmit sequencer. Disabling aborts even a character in flight.
  always_ff @(posedge clk) begin
    if (reset || !en) begin
      st <= SSP_TX_IDLE; // RULE1
      rts <= 1'b0;
      txd <= 1'b1;
      sh <= 12'hFFF;
      left <= 4'h0;
      bit_cnt <= '0;
    end else begin
      bit_cnt <= (st != SSP_TX_SEND || bit_tick) ? '0 : bit_cnt + 19'h1;
      unique case (st)
        SSP_TX_IDLE: begin
          if (fifo_out_valid) begin
            rts <= 1'b1;
            st <= SSP_TX_LEAD;
          end
        end
        SSP_TX_LEAD: begin
          if (lead_done) st <= SSP_TX_CTS; // RULE8
        end
        SSP_TX_CTS: begin
          if (load) begin
            txd <= 1'b0; // RULE13
            sh <= tx_frame;
            left <= tx_len;
            st <= SSP_TX_SEND;
          end
        end
        SSP_TX_SEND: begin
          if (char_end) begin
            st <= fifo_out_valid ? SSP_TX_CTS : SSP_TX_TAIL;
          end else if (bit_tick) begin
            txd <= sh[0]; // RULE13
            sh <= {1'b1, sh[11:1]};
            left <= left - 4'h1;
          end
        end
        SSP_TX_TAIL: begin
          if (fifo_out_valid) begin
            st <= SSP_TX_CTS;
          end else if (tail_done) begin
            rts <= 1'b0; // RULE9
            st <= SSP_TX_IDLE;
          end
        end
      endcase
    end
  end

  // Helper ages for the delay checks, saturating.
  logic [31:0] rts_age;
  logic [31:0] high_age;
  always_ff @(posedge clk) begin
    if (reset || !rts) rts_age <= 32'h0;
    else if (rts_age != 32'hFFFFFFFF) rts_age <= rts_age + 32'h1;
    if (reset || !rts || !txd) high_age <= 32'h0;
    else if (high_age != 32'hFFFFFFFF) high_age <= high_age + 32'h1;
  end

  dis_quiet_a: assert property (@(posedge clk) disable iff (reset)
    $past(!en) |-> txd && !rts) else $error("disabled port drives line"); // RULE1
  baud_tick_a: assert property (@(posedge clk) disable iff (reset)
    st == SSP_TX_SEND && $past(st) == SSP_TX_SEND && $changed(txd) && $stable(ctrl)
    |-> $past(bit_cnt) == bit_div - 19'h1) else $error("bit period wrong"); // RULE2
  start_rts_a: assert property (@(posedge clk) disable iff (reset)
    $fell(txd) |-> rts && st == SSP_TX_SEND) else $error("start without rts"); // RULE13
  lead_time_a: assert property (@(posedge clk) disable iff (reset)
    $fell(txd) && $stable(lead_ms) |-> $past(rts_age) >= {16'h0, lead_ms} * MS_CYCLES)
    else $error("lead delay short"); // RULE8
  tail_time_a: assert property (@(posedge clk) disable iff (reset)
    $fell(rts) && $past(en) && $stable(tail_ms)
    |-> $past(high_age) >= {16'h0, tail_ms} * MS_CYCLES)
    else $error("tail delay short"); // RULE9
  cts_gate_a: assert property (@(posedge clk) disable iff (reset)
    $fell(txd) && $past(cts_use) |-> $past(cts_s)) else $error("sent without cts"); // RULE10
  cts_ignore_a: assert property (@(posedge clk) disable iff (reset)
    st == SSP_TX_CTS && !cts_use && fifo_out_valid |=> st != SSP_TX_CTS)
    else $error("waited on ignored cts"); // RULE11
  node_match_a: assert property (@(posedge clk) disable iff (reset)
    en && rx_valid && addr_wait && !rx_gap && !addr_match |=> !selected && $stable(rx_buf))
    else $error("foreign message taken"); // RULE12
  parity_bit_a: assert property (@(posedge clk) disable iff (reset)
    load && par_mode == SSP_PAR_MARK |=> sh[n_data] == 1'b1)
    else $error("mark parity not one"); // RULE14
endmodule
`default_nettype wire

/* File: ssp_master_model.sv */
/*
  Polling master model at the far end of the serial line.
  Assumes the bench sets the frame length; the line idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_master_model #(
  parameter int DIV = 347
) (
  // Clock.
  input wire logic clk,
  // Serial line.
  input wire logic txd,
  output logic rxd
);
  int nbits = 9; // Bits captured after the start bit.
  logic [11:0] got[$]; // Frames seen, start bit in bit 0.
  initial rxd = 1'b1;
  // Mid-bit sampling, so a cycle of skew cannot corrupt a bit.
  always begin
    logic [11:0] w;
    @(negedge txd);
    repeat (DIV / 2) @(posedge clk);
    w = '0;
    for (int i = 0; i <= nbits; i++) begin
      w[i] = txd;
      if (i < nbits) repeat (DIV) @(posedge clk);
    end
    got.push_back(w);
  end
  // Sends a frame built with the port's parity and stop count.
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (DIV) @(posedge clk);
    end
    // The last stop bit leaves the line high, so a next frame may follow at once.
  endtask
endmodule
`default_nettype wire

/* File: serial_slave_port_framing_test.sv */
/*
  Testbench of the serial slave port: register tasks and serial scenarios.
  Assumes the master model sits on txd and rxd.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssp_cfg.svh"
module serial_slave_port_framing_test;
  import ssp_pkg::*;
  localparam int MS = 4; // Short millisecond keeps delays brief.
  localparam int DIV = 347; // Clocks per bit at the fastest rate.
  logic clk, reset, read, write, rxd, txd, rts, waitrequest;
  logic cts = 1'b0;
  logic [2:0] address = 3'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  int mismatches = 0;
  int num_checks = 0;
  ssp_top #(.MS_CYCLES(MS), .FIFO_DEPTH(8)) i_ssp_top (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .rxd(rxd), .txd(txd),
    .rts(rts), .cts(cts));
  ssp_master_model #(.DIV(DIV)) i_ssp_master_model (.clk(clk), .txd(txd), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Holds the request until waitrequest is seen low, then releases it.
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] ctrl(logic g, logic [2:0] pm, int nb, int st, logic en);
    return {20'h0, 4'hB, 2'(nb - 5), pm, 1'(st - 1), g, en};
  endfunction
  // Start low, data LSB first, parity, then high stops.
  function automatic logic [11:0] frame(logic [7:0] d, int nb, logic [2:0] pm, int st, int len);
    logic [11:0] f;
    logic p;
    f = '1;
    f[0] = 1'b0;
    p = 1'b0;
    for (int k = 0; k < nb; k++) begin
      f[k + 1] = d[k];
      p ^= d[k];
    end
    if (pm != 3'h0) f[nb + 1] = (pm == 3'h1) ? ~p : (pm == 3'h2) ? p : (pm == 3'h3);
    return f & ~(12'hFFF << len);
  endfunction
  task automatic expect_frame(input logic [11:0] f);
    int n;
    n = 0;
    while (i_ssp_master_model.got.size() == 0 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    chk(i_ssp_master_model.got.size(), 1);
    if (n < 6000) chk(i_ssp_master_model.got.pop_front(), f);
  endtask
  task automatic tx_one(input logic [7:0] d, input logic [2:0] pm, input int nb, input int st);
    int n, len;
    len = 1 + nb + int'(pm != 3'h0) + st;
    i_ssp_master_model.nbits = len - 1;
    bus(1'b1, `SSP_REG_CTRL, ctrl(1'b0, pm, nb, st, 1'b1));
    bus(1'b1, `SSP_REG_TXD, {24'h0, d});
    n = 0;
    while (txd === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(rts, 1'b1);
    chk(n >= 2 * MS && n <= 2 * MS + 5, 1'b1);
    expect_frame(frame(d, nb, pm, st, len));
    n = 0;
    while (rts === 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    chk(n >= 170 + 3 * MS && n <= 190 + 3 * MS, 1'b1);
  endtask
  // Stops a hung run.
  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial begin
    reset = 1'b1;
    read = 1'b0;
    write = 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({rts, txd}, 2'b01);
    bus(1'b0, `SSP_REG_CTRL, 32'h0);
    chk(q, 32'h4C1);
    bus(1'b0, `SSP_REG_NODE, 32'h0);
    chk(q, 32'h1);
    bus(1'b0, 3'h7, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `SSP_REG_LEAD, 32'h2);
    bus(1'b1, `SSP_REG_TAIL, 32'h3);
    $display("registers done");
    tx_one(8'hB6, SSP_PAR_NONE, 8, 1);
    tx_one(8'h5B, SSP_PAR_ODD, 7, 1);
    tx_one(8'h2D, SSP_PAR_EVEN, 6, 2);
    tx_one(8'h16, SSP_PAR_MARK, 5, 1);
    tx_one(8'hC3, SSP_PAR_SPACE, 8, 2);
    $display("framing done");
    bus(1'b1, `SSP_REG_CTRL, ctrl(1'b1, SSP_PAR_NONE, 8, 1, 1'b1));
    i_ssp_master_model.nbits = 9;
    bus(1'b1, `SSP_REG_TXD, 32'h3C);
    repeat (400) @(posedge clk);
    chk({rts, txd}, 2'b11);
    cts <= 1'b1;
    expect_frame(frame(8'h3C, 8, 3'h0, 1, 10));
    cts <= 1'b0;
    $display("gating done");
    bus(1'b1, `SSP_REG_CTRL, ctrl(1'b0, SSP_PAR_EVEN, 8, 1, 1'b1));
    bus(1'b1, `SSP_REG_NODE, 32'h5A);
    i_ssp_master_model.send(frame(8'h5A, 8, SSP_PAR_EVEN, 1, 11), 11);
    bus(1'b0, `SSP_REG_RXD, 32'h0);
    chk(q, 32'h15A);
    i_ssp_master_model.send(frame(8'h33, 8, SSP_PAR_EVEN, 1, 11) ^ 12'h200, 11);
    bus(1'b0, `SSP_REG_RXD, 32'h0);
    chk(q, 32'h333);
    repeat (12 * DIV) @(posedge clk);
    i_ssp_master_model.send(frame(8'h11, 8, SSP_PAR_EVEN, 1, 11), 11);
    i_ssp_master_model.send(frame(8'h22, 8, SSP_PAR_EVEN, 1, 11), 11);
    bus(1'b0, `SSP_REG_STAT, 32'h0);
    chk({q[6], q[0]}, 2'b10);
    $display("receive done");
    bus(1'b1, `SSP_REG_CTRL, ctrl(1'b0, SSP_PAR_NONE, 8, 1, 1'b1));
    for (int k = 0; k < 10; k++) bus(1'b1, `SSP_REG_TXD, 32'h40 + k);
    chk(i_ssp_master_model.got.size() > 0, 1'b1);
    for (int k = 0; k < 10; k++) expect_frame(frame(8'(k + 64), 8, 3'h0, 1, 10));
    $display("buffer done");
    bus(1'b1, `SSP_REG_CTRL, ctrl(1'b0, SSP_PAR_NONE, 8, 1, 1'b0));
    bus(1'b1, `SSP_REG_TXD, 32'h55);
    i_ssp_master_model.send(frame(8'h5A, 8, 3'h0, 1, 10), 10);
    repeat (400) @(posedge clk);
    chk({rts, txd}, 2'b01);
    bus(1'b0, `SSP_REG_STAT, 32'h0);
    chk(q[0], 1'b0);
    chk(q[19:16], 4'h1);
    $display("disable done");
    stop_test();
  end
endmodule
`default_nettype wire
